// ---- bench/rsc_ctl_model.sv ----
/*
 Model of the slot controller that drives the relay state block: it offers
 one request per falling edge and turns slot addresses into channel fields.
 Assumes the design samples requests on the rising edge of core_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module rsc_ctl_model (
   // Clock.
   input wire logic core_clk,
   // Request towards the card.
   output rsc_pkg::rsc_req_s req,
   output logic req_valid,
   // Answer from the card.
   input wire rsc_pkg::rsc_rsp_s rsp,
   input wire logic busy
);
   // ==================================================================
   // Request driver
   // ==================================================================

   // Start idle so that nothing is offered while the card is in reset.
   initial begin
      req = '0;
      req_valid = 1'b0;
   end

   // Offer one request; addr is slot times one hundred plus channel.
   task automatic send(input rsc_pkg::rsc_cmd_e cmd, input int addr,
      input logic [7:0] data);
      int n = 0;
      // A query walk must drain first, or the card drops the request.
      while (busy === 1'b1 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      @(negedge core_clk);
      req.cmd = cmd;
      req.data = data;
      req.ch = 3'(addr % 100);
      req_valid = 1'b1;
   endtask : send

   // Withdraw the strobe; the data and channel fields flip so stale data is unkind.
   task automatic idle();
      @(negedge core_clk);
      req_valid = 1'b0;
      req.data = ~req.data;
      req.ch = ~req.ch;
   endtask : idle

   // An all-zero identity marks an empty slot.
   function automatic logic slot_empty(input logic [23:0] id);
      return id === 24'h000000;
   endfunction : slot_empty

endmodule : rsc_ctl_model

`default_nettype wire

// ---- bench/test_eight_channel_relay_state_control.sv ----
/*
 Self-checking bench for the relay state block: a table of state-changing
 requests each read back, then queries, identity, slot reset and resets.
 Assumes the controller model and the package are compiled before it.
*/
`timescale 1ns/100ps
`default_nettype none

module test_eight_channel_relay_state_control;
   // ==================================================================
   // Signals and table
   // ==================================================================
   logic core_clk, rstn, req_valid, term_attached, busy;
   rsc_pkg::rsc_req_s req;
   rsc_pkg::rsc_rsp_s rsp;
   logic [7:0] relay_on;
   int mismatches = 0;
   int samples_checked = 0;
   // Rows: command, data, channel, state expected after the command.
   localparam int NR = 8;
   rsc_pkg::rsc_cmd_e row_cmd [NR] = '{rsc_pkg::CMD_WRITE,
      rsc_pkg::CMD_CLOSE, rsc_pkg::CMD_OPEN, rsc_pkg::CMD_CHWR,
      rsc_pkg::CMD_CHWR, rsc_pkg::CMD_WRITE, rsc_pkg::CMD_WRITE,
      rsc_pkg::CMD_WRITE};
   logic [7:0] row_dat [NR] = '{8'h29, 8'h84, 8'h09, 8'h01, 8'h00, 8'hFF,
      8'h00, 8'h6A};
   int row_ch [NR] = '{0, 0, 0, 1, 7, 0, 0, 0};
   logic [7:0] row_exp [NR] = '{8'h29, 8'hAD, 8'hA4, 8'hA6, 8'h26, 8'hFF,
      8'h00, 8'h6A};

   rsc_relay_ctrl i_dut (.core_clk(core_clk), .rstn(rstn), .req(req),
      .req_valid(req_valid), .term_attached(term_attached), .rsp(rsp),
      .busy(busy), .relay_on(relay_on));

   rsc_ctl_model i_ctl (.core_clk(core_clk), .req(req),
      .req_valid(req_valid), .rsp(rsp), .busy(busy));

   // ==================================================================
   // Helpers
   // ==================================================================

   // Free-running 100 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // One comparison; a miss is printed at once and counted.
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Read the whole word and compare it and the relay drive to exp.
   // The answer stands for one cycle only, so it is looked at on the
   // falling edge where the strobe is withdrawn, not one cycle later.
   task automatic read_state(input logic [7:0] exp);
      i_ctl.send(rsc_pkg::CMD_READ, 400, 8'h00);
      i_ctl.idle();
      chk({23'h0, rsp.valid}, 24'h000001);
      chk(rsp.data, {16'h0000, exp});
      chk({16'h0000, relay_on}, {16'h0000, exp});
   endtask : read_state

   // Query a channel mask; items must follow ascending channel order.
   task automatic query(input logic [7:0] mask, input logic [7:0] st);
      logic q [$];
      int k = 0;
      for (int c = 0; c < 8; c++) begin
         if (mask[c]) begin
            q.push_back(st[c]);
         end
      end
      // An empty list still answers with one closing item.
      if (q.size() == 0) begin
         q.push_back(1'b0);
      end
      i_ctl.send(rsc_pkg::CMD_QUERY, 400, mask);
      i_ctl.idle();
      // Busy is up one cycle after a list is taken; an empty list answers
      // at once, so the first look comes before the first wait.
      chk({23'h0, busy}, {23'h0, mask != 8'h00});
      for (int w = 0; w < 12; w++) begin
         if (rsp.valid === 1'b1) begin
            chk(rsp.data, {23'h0, q[k]});
            k++;
            if (rsp.last === 1'b1 || k == q.size()) begin
               break;
            end
         end
         @(negedge core_clk);
      end
      chk(24'(k), 24'(q.size()));
      chk({23'h0, rsp.last}, 24'h000001);
      // Busy has fallen by the time the final item is out.
      chk({23'h0, busy}, 24'h000000);
   endtask : query

   // Print the counts and the verdict, then stop.
   task automatic end_of_test();
      $display("Compared %0d, mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_of_test

   // Watchdog: the sequence needs some 65 cycles, this allows 2000.
   initial begin
      #20000;
      mismatches++;
      end_of_test();
   end

   // ==================================================================
   // Main sequence
   // ==================================================================
   initial begin
      rstn = 1'b0;
      term_attached = 1'b1;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      chk({16'h0000, relay_on}, 24'h000000);
      read_state(8'h00);
      // Table of state changes, each read back in full.
      for (int i = 0; i < NR; i++) begin
         i_ctl.send(row_cmd[i], 400 + row_ch[i], row_dat[i]);
         i_ctl.idle();
         read_state(row_exp[i]);
      end
      // Back-to-back requests, one per cycle, each touching some bits.
      i_ctl.send(rsc_pkg::CMD_WRITE, 400, 8'h0F);
      i_ctl.send(rsc_pkg::CMD_CLOSE, 400, 8'h30);
      i_ctl.send(rsc_pkg::CMD_OPEN, 400, 8'h01);
      i_ctl.idle();
      read_state(8'h3E);
      query(8'hC5, 8'h3E);
      query(8'h00, 8'h3E);
      // Identity with the terminal module absent, then present.
      for (int t = 0; t < 2; t++) begin
         term_attached = t[0];
         i_ctl.send(rsc_pkg::CMD_IDENTITY, 400, 8'h00);
         i_ctl.idle();
         chk(rsp.data, t ? rsc_pkg::ID_FULL : rsc_pkg::ID_FAMILY);
         chk({23'h0, i_ctl.slot_empty(rsp.data)}, 24'h000000);
      end
      // Slot reset command from a non-zero state.
      i_ctl.send(rsc_pkg::CMD_RESET, 400, 8'h00);
      i_ctl.idle();
      read_state(8'h00);
      // Reset pin pulled in mid-run after a write.
      i_ctl.send(rsc_pkg::CMD_WRITE, 400, 8'h5A);
      i_ctl.idle();
      read_state(8'h5A);
      rstn = 1'b0;
      @(negedge core_clk);
      chk({16'h0000, relay_on}, 24'h000000);
      rstn = 1'b1;
      read_state(8'h00);
      end_of_test();
   end

endmodule : test_eight_channel_relay_state_control

`default_nettype wire

// ---- rtl/rsc_pkg.sv ----
/*
 Package for the eight-channel relay state control block: command codes,
 field widths, reset values and the carrier structs for requests/answers.
 Assumes it is compiled before the design module that uses it.
*/
package rsc_pkg;

   // ==================================================================
   // Widths and reset values
   // ==================================================================

   // Number of relay channels on the card.
   localparam int unsigned NUM_CH = 8;
   // Width of a channel index.
   localparam int unsigned CH_W = 3;
   // Power-on value of the channel state word: every channel open.
   localparam logic [7:0] STATE_RESET = 8'h00;
   // Value of a single channel bit that opens the channel.
   localparam logic BIT_OPEN = 1'b0;
   // Value of a single channel bit that closes the channel.
   localparam logic BIT_CLOSED = 1'b1;
   // Width of an identity code.
   localparam int unsigned ID_W = 24;
   // Full product identity; the value is arbitrary.
   localparam logic [23:0] ID_FULL = 24'h5A5A01;
   // Family identity without the product suffix; the value is arbitrary.
   localparam logic [23:0] ID_FAMILY = 24'h5A5AFF;

   // ==================================================================
   // Commands
   // ==================================================================

   // Command codes, one-hot except CMD_NONE, so a decode is one bit test.
   typedef enum logic [7:0] {
      CMD_NONE     = 8'h00,
      CMD_WRITE    = 8'h01,
      CMD_READ     = 8'h02,
      CMD_CHWR     = 8'h04,
      CMD_CLOSE    = 8'h08,
      CMD_OPEN     = 8'h10,
      CMD_QUERY    = 8'h20,
      CMD_RESET    = 8'h40,
      CMD_IDENTITY = 8'h80
   } rsc_cmd_e;

   // One request from the controller.
   typedef struct packed {
      rsc_cmd_e   cmd;   // What to do.
      logic [7:0] data;  // Whole word, channel list mask, or channel bit.
      logic [2:0] ch;    // Channel index for a single-channel write.
   } rsc_req_s;

   // One answer to the controller.
   typedef struct packed {
      logic        valid; // One-cycle answer strobe.
      logic        last;  // Final item of this answer.
      logic [23:0] data;  // Word, channel bit, or identity code.
   } rsc_rsp_s;

endpackage : rsc_pkg

// ---- rtl/rsc_relay_ctrl.sv ----
/*
 Channel-state logic of an eight-channel relay switching card.
 Holds one 8-bit state word that drives the relay outputs, and answers
 reads, per-channel queries and identity queries from the slot controller.
 Assumes requests arrive synchronous to core_clk, one per cycle at most,
 and that no request is offered while busy is high.
*/
// What this block does
// - Bit n drives relay channel n.
// - Bit zero opens, bit one closes channel.
// - Whole word ranges 0 to 255.
// - Whole write loads all eight bits together.
// - Whole read returns current eight-bit state.
// - Single-channel write changes only addressed bit.
// - Close list sets each named bit.
// - Open list clears each named bit.
// - Query reports listed channels, one by one.
// - Slot reset restores all power-on state.
// - Identity full only with terminal module attached.
`timescale 1ns/100ps
`default_nettype none

module rsc_relay_ctrl (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Request from the slot controller.
   input wire rsc_pkg::rsc_req_s req,
   input wire logic req_valid,
   // Terminal module presence, high while attached.
   input wire logic term_attached,
   // Answer to the slot controller.
   output rsc_pkg::rsc_rsp_s rsp,
   output logic busy,
   // Relay drive, one bit per channel.
   output logic [7:0] relay_on
);

   // ==================================================================
   // State
   // ==================================================================

   // Query walker states.
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WALK = 2'b10
   } rsc_walk_e;

   // Programmed channel state word.
   logic [7:0] state_r;
   // Channels still to be reported by a query.
   logic [7:0] pend_r;
   // Query walker state.
   rsc_walk_e walk_r;
   // Registered answer.
   rsc_pkg::rsc_rsp_s rsp_r;
   // Lowest pending channel and the mask left after it.
   logic [2:0] low_idx;
   logic [7:0] pend_nxt;
   // Accepted request strobe.
   logic take;

   assign take = req_valid && (walk_r == ST_IDLE);

   // ==================================================================
   // Channel state word
   // ==================================================================

   // Each channel bit is updated on its own; a bit not named keeps its
   // value, so list commands never disturb their neighbours.
   genvar gi;
   generate
      for (gi = 0; gi < rsc_pkg::NUM_CH; gi++) begin : g_ch
         always_ff @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               state_r[gi] <= rsc_pkg::STATE_RESET[gi];
            end else if (take) begin
               case (req.cmd)
                  rsc_pkg::CMD_RESET: begin
                     state_r[gi] <= rsc_pkg::STATE_RESET[gi];
                  end
                  rsc_pkg::CMD_WRITE: begin
                     // Full word load; any 0..255 value is legal.
                     state_r[gi] <= req.data[gi];
                  end
                  rsc_pkg::CMD_CHWR: begin
                     if (req.ch == gi) begin
                        state_r[gi] <= req.data[0];
                     end
                  end
                  rsc_pkg::CMD_CLOSE: begin
                     if (req.data[gi]) begin
                        state_r[gi] <= rsc_pkg::BIT_CLOSED;
                     end
                  end
                  rsc_pkg::CMD_OPEN: begin
                     if (req.data[gi]) begin
                        state_r[gi] <= rsc_pkg::BIT_OPEN;
                     end
                  end
                  default: begin
                     state_r[gi] <= state_r[gi];
                  end
               endcase
            end
         end
      end
   endgenerate

   // Relays follow the word one cycle later; bit n is channel n, 1 is closed.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         relay_on <= rsc_pkg::STATE_RESET;
      end else begin
         relay_on <= state_r;
      end
   end

   // ==================================================================
   // Query walker
   // ==================================================================

   // Lowest set bit of the pending mask; list order is ascending channel.
   always_comb begin
      low_idx = 3'h0;
      for (int i = rsc_pkg::NUM_CH - 1; i >= 0; i--) begin
         if (pend_r[i]) begin
            low_idx = 3'(i);
         end
      end
      pend_nxt = pend_r & ~(8'h01 << low_idx);
   end

   // A query walks its mask one channel per cycle, so the answers come
   // out as separate items; any request offered during a walk is dropped.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         walk_r <= ST_IDLE;
         pend_r <= 8'h00;
      end else begin
         case (walk_r)
            ST_IDLE: begin
               if (take && req.cmd == rsc_pkg::CMD_QUERY &&
                   req.data != 8'h00) begin
                  walk_r <= ST_WALK;
                  pend_r <= req.data;
               end
            end
            ST_WALK: begin
               pend_r <= pend_nxt;
               if (pend_nxt == 8'h00) begin
                  walk_r <= ST_IDLE;
               end
            end
            default: begin
               walk_r <= ST_IDLE;
               pend_r <= 8'h00;
            end
         endcase
      end
   end

   // ==================================================================
   // Answers
   // ==================================================================

   // Read, identity and each query item produce a one-cycle strobe.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rsp_r <= '0;
      end else begin
         rsp_r <= '0;
         if (walk_r == ST_WALK) begin
            rsp_r.valid <= 1'b1;
            rsp_r.last <= (pend_nxt == 8'h00);
            rsp_r.data <= {23'h000000, state_r[low_idx]};
         end else if (take) begin
            case (req.cmd)
               rsc_pkg::CMD_READ: begin
                  rsp_r.valid <= 1'b1;
                  rsp_r.last <= 1'b1;
                  rsp_r.data <= {16'h0000, state_r};
               end
               rsc_pkg::CMD_IDENTITY: begin
                  rsp_r.valid <= 1'b1;
                  rsp_r.last <= 1'b1;
                  // Without the terminal module only the family code.
                  rsp_r.data <= term_attached ? rsc_pkg::ID_FULL
                                              : rsc_pkg::ID_FAMILY;
               end
               rsc_pkg::CMD_QUERY: begin
                  // An empty list still gets a closing, empty answer.
                  if (req.data == 8'h00) begin
                     rsp_r.valid <= 1'b1;
                     rsp_r.last <= 1'b1;
                  end
               end
               default: begin
                  rsp_r.valid <= 1'b0;
               end
            endcase
         end
      end
   end

   assign rsp = rsp_r;

   // Busy is a flop: high in the cycle after a query with a list is taken.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy <= 1'b0;
      end else if (walk_r == ST_WALK) begin
         busy <= (pend_nxt != 8'h00);
      end else begin
         busy <= take && req.cmd == rsc_pkg::CMD_QUERY && req.data != 8'h00;
      end
   end

   // ==================================================================
   // Assertions
   // ==================================================================

   // Whole write loads the written word into the state word one cycle later.
   sequence s_write;
      take && req.cmd == rsc_pkg::CMD_WRITE;
   endsequence

   property p_write_load;
      @(posedge core_clk) disable iff (!rstn)
      s_write |=> state_r == $past(req.data);
   endproperty
   a_write_load: assert property (p_write_load)
      else $error("Whole write did not load the state word.");

   property p_relay_follow;
      @(posedge core_clk) disable iff (!rstn)
      1'b1 |=> relay_on == $past(state_r);
   endproperty
   a_relay_follow: assert property (p_relay_follow)
      else $error("Relay drive does not follow the state word.");

   property p_read;
      @(posedge core_clk) disable iff (!rstn)
      take && req.cmd == rsc_pkg::CMD_READ |=>
         rsp.valid && rsp.data[7:0] == $past(state_r);
   endproperty
   a_read: assert property (p_read)
      else $error("Read did not return the state word.");

   property p_chwr;
      @(posedge core_clk) disable iff (!rstn)
      take && req.cmd == rsc_pkg::CMD_CHWR |=>
         state_r[$past(req.ch)] == $past(req.data[0]) &&
         ((state_r ^ $past(state_r)) & ~(8'h01 << $past(req.ch))) == 8'h00;
   endproperty
   a_chwr: assert property (p_chwr)
      else $error("Single-channel write touched the wrong bits.");

   property p_close;
      @(posedge core_clk) disable iff (!rstn)
      take && req.cmd == rsc_pkg::CMD_CLOSE |=>
         state_r == ($past(state_r) | $past(req.data));
   endproperty
   a_close: assert property (p_close)
      else $error("Close list did not set exactly the named bits.");

   property p_open;
      @(posedge core_clk) disable iff (!rstn)
      take && req.cmd == rsc_pkg::CMD_OPEN |=>
         state_r == ($past(state_r) & ~$past(req.data));
   endproperty
   a_open: assert property (p_open)
      else $error("Open list did not clear exactly the named bits.");

   property p_reset;
      @(posedge core_clk) disable iff (!rstn)
      take && req.cmd == rsc_pkg::CMD_RESET |=>
         state_r == rsc_pkg::STATE_RESET ##1
         relay_on == rsc_pkg::STATE_RESET;
   endproperty
   a_reset: assert property (p_reset)
      else $error("Slot reset did not restore the power-on state.");

   property p_ident;
      @(posedge core_clk) disable iff (!rstn)
      take && req.cmd == rsc_pkg::CMD_IDENTITY |=> rsp.valid &&
         rsp.data == ($past(term_attached) ? rsc_pkg::ID_FULL
                                           : rsc_pkg::ID_FAMILY);
   endproperty
   a_ident: assert property (p_ident)
      else $error("Identity answer does not match module presence.");

   property p_query_len;
      @(posedge core_clk) disable iff (!rstn)
      take && req.cmd == rsc_pkg::CMD_QUERY && req.data == 8'h03 |=>
         ##1 (rsp.valid && !rsp.last) ##1 (rsp.valid && rsp.last);
   endproperty
   a_query_len: assert property (p_query_len)
      else $error("Two-channel query did not answer twice in order.");

endmodule : rsc_relay_ctrl

`default_nettype wire
